// ==== rtl/wdtk_watchdog.sv ====
// Keyed watchdog timer with register port, reset requests and interrupt.
//
// Operation
// [R01] Counter advances on sub clock, from RC or crystal source by select register.
// [R02] Time-out select picks period 2^8,10,12,14,15,16,17,18 sub clocks.
// [R03] Key 10101B disables the watchdog, key 01010B enables it.
// [R04] Any other key value requests device reset after soft reset delay.
// [R05] Reset from a bad key sets the key fault flag, bit 0.
// [R06] Software clears the key fault flag by writing 0; writing 1 does nothing.
// [R07] After reset the key field is 01010B and the time-out select 011.
// [R08] Overflow in normal run requests device reset and sets time-out flag.
// [R09] Overflow in sleep or idle sets time-out flag, resets only PC and SP.
// [R10] Count is cleared by bad-key reset, clear instruction, or halt.
// [R11] Software must clear the watchdog before the selected period elapses.
// [R12] Reset flag register bits 6 to 4 always read as zero.
// [R13] Halt with watchdog and low voltage detector off clears and stops the watchdog.
// [R14] Halt with sub clock running clears the watchdog, which resumes if enabled.
// [R15] Free running 18-bit counter, overflow at selected tap, clears to zero.
// [R16] Bad key reset pends for the delay, then is a one cycle request.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module wdtk_watchdog #(
  parameter int CNT_W        = wdtk_pkg::WDT_CNT_WIDTH,
  parameter int SRESET_CYCLES = wdtk_pkg::SOFT_RESET_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       low_speed_rc_osc,
  input  wire logic       low_speed_crystal_osc,
  input  wire logic       clear_watchdog_instr,
  input  wire logic       halt_instr,
  input  wire logic       low_power_mode,
  input  wire logic       lvd_enabled,
  input  wire logic       wakeup,
  output logic            device_reset_req,
  output logic            pc_sp_reset_req,
  output logic            timeout_status_flag,
  output logic            key_fault_reset_flag,
  output logic            watchdog_enabled,
  output logic            watchdog_stopped,
  output logic            idle_sysclk_keep,
  output logic            irq
);
  import wdtk_pkg::*;

  // ************************************************
  // Elaboration checks
  // ************************************************
  if (CNT_W < 18) begin : g_bad_width
    $error("Counter must be at least 18 bits wide.");
  end
  if (SRESET_CYCLES < 1 || SRESET_CYCLES > 65535) begin : g_bad_delay
    $error("Soft reset delay must be 1 to 65535 cycles.");
  end

  // ************************************************
  // Declarations
  // ************************************************
  wdtk_sub_if sub ();

  logic [7:0]       wdt_ctrl_q;
  logic             keyfault_q;
  logic             sysclk_keep_q;
  logic             sub_sel_q;
  logic             timeout_q;
  logic             stopped_q;
  logic [1:0]       irq_stat_q;
  logic [1:0]       irq_mask_q;
  logic [CNT_W-1:0] cnt_q;
  logic [15:0]      delay_q;
  wdtk_key_state_t  key_state_q;
  logic [7:0]       rdata_q;
  logic             dev_rst_q;
  logic             pcsp_rst_q;
  logic [4:0]       key;
  logic             key_valid;
  logic             enabled;
  logic             fire;
  logic             clear_cnt;
  logic             at_tap;
  logic             overflow;
  logic             wr_ctrl;
  logic             wr_flags;
  logic             wr_stat;
  logic             wr_sel;
  logic             wr_istat;
  logic             wr_imask;
  logic [7:0]       rdata_d;

  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [CNT_W-1:0] tap_last(input logic [2:0] sel);
    int exp;
    case (sel)
      3'h0:    exp = 8;
      3'h1:    exp = 10;
      3'h2:    exp = 12;
      3'h3:    exp = 14;
      3'h4:    exp = 15;
      3'h5:    exp = 16;
      3'h6:    exp = 17;
      default: exp = 18;
    endcase
    return {CNT_W{1'b1}} >> (CNT_W - exp);
  endfunction : tap_last

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ref_addr);
    return addr == ref_addr;
  endfunction : hit

  // ************************************************
  // Sub clock source
  // ************************************************
  assign sub.use_crystal = sub_sel_q; // [R01]

  wdtk_sub_clock u_sub_clock (
    .core_clk              (core_clk),
    .sys_rst               (sys_rst),
    .low_speed_rc_osc      (low_speed_rc_osc),
    .low_speed_crystal_osc (low_speed_crystal_osc),
    .sub                   (sub.src)
  );

  // ************************************************
  // Decode
  // ************************************************
  assign wr_ctrl  = reg_wr & hit(reg_addr, ADDR_WDT_CTRL);
  assign wr_flags = reg_wr & hit(reg_addr, ADDR_RST_FLAGS);
  assign wr_stat  = reg_wr & hit(reg_addr, ADDR_WDT_STAT);
  assign wr_sel   = reg_wr & hit(reg_addr, ADDR_SUB_SEL);
  assign wr_istat = reg_wr & hit(reg_addr, ADDR_IRQ_STAT);
  assign wr_imask = reg_wr & hit(reg_addr, ADDR_IRQ_MASK);

  assign key       = wdt_ctrl_q[7:KEY_LSB];
  assign key_valid = (key == KEY_ENABLE) || (key == KEY_DISABLE);
  assign enabled   = (key == KEY_ENABLE) && (key_state_q == WDTK_RUN); // [R03]
  assign fire      = key_state_q == WDTK_FIRE;

  // ************************************************
  // Control register
  // ************************************************
  // A fired key fault returns the register to its power-on value, so the part restarts enabled.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wdt_ctrl_q <= WDT_CTRL_RESET; // [R07]
    end else if (fire) begin
      wdt_ctrl_q <= WDT_CTRL_RESET;
    end else if (wr_ctrl) begin
      wdt_ctrl_q <= reg_wdata;
    end
  end

  // ************************************************
  // Key check and soft reset delay
  // ************************************************
  // Once pending, the reset is not withdrawn by a later valid key.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      key_state_q <= WDTK_RUN;
      delay_q     <= 16'h0000;
    end else begin
      case (key_state_q)
        WDTK_RUN: begin
          if (!key_valid) begin // [R04]
            key_state_q <= WDTK_PEND;
            delay_q     <= 16'(SRESET_CYCLES - 1);
          end
        end
        WDTK_PEND: begin
          if (delay_q == 16'h0000) begin // [R16]
            key_state_q <= WDTK_FIRE;
          end else begin
            delay_q <= delay_q - 16'h0001;
          end
        end
        WDTK_FIRE: begin
          key_state_q <= WDTK_RUN;
        end
        default: begin
          key_state_q <= WDTK_RUN;
        end
      endcase
    end
  end

  // ************************************************
  // Reset flag register
  // ************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      keyfault_q    <= FLAGS_RESET[FLAG_KEYFAULT];
      sysclk_keep_q <= FLAGS_RESET[FLAG_SYSCLK];
    end else begin
      if (fire) begin
        keyfault_q <= 1'b1; // [R05]
      end else if (wr_flags && !reg_wdata[FLAG_KEYFAULT]) begin
        keyfault_q <= 1'b0; // [R06]
      end
      if (wr_flags) begin
        sysclk_keep_q <= reg_wdata[FLAG_SYSCLK];
      end
    end
  end

  // ************************************************
  // Sub clock select
  // ************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sub_sel_q <= SUB_SEL_RESET;
    end else if (wr_sel) begin
      sub_sel_q <= reg_wdata[0];
    end
  end

  // ************************************************
  // Stop state for halt with everything off
  // ************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stopped_q <= 1'b0;
    end else if (halt_instr) begin
      stopped_q <= !enabled && !lvd_enabled; // [R13] [R14]
    end else if (wakeup) begin
      stopped_q <= 1'b0;
    end
  end

  // ************************************************
  // Watchdog counter
  // ************************************************
  assign clear_cnt = fire || clear_watchdog_instr || halt_instr; // [R10]
  assign at_tap    = cnt_q == tap_last(wdt_ctrl_q[2:0]); // [R02]
  assign overflow  = sub.tick && enabled && !stopped_q && at_tap && !clear_cnt;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (clear_cnt) begin
      cnt_q <= '0; // [R10]
    end else if (sub.tick && enabled && !stopped_q) begin // [R01]
      if (at_tap) begin
        cnt_q <= '0; // [R15]
      end else begin
        cnt_q <= cnt_q + 1'b1; // [R15]
      end
    end
  end

  // ************************************************
  // Reset requests
  // ************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dev_rst_q  <= 1'b0;
      pcsp_rst_q <= 1'b0;
    end else begin
      dev_rst_q  <= fire || (overflow && !low_power_mode); // [R04] [R08]
      pcsp_rst_q <= overflow && low_power_mode; // [R09]
    end
  end

  // ************************************************
  // Time-out flag
  // ************************************************
  // Halt clears the flag; it also clears the counter, so no overflow can occur in the same cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timeout_q <= 1'b0;
    end else if (overflow) begin
      timeout_q <= 1'b1; // [R08] [R09]
    end else if (halt_instr || (wr_stat && !reg_wdata[0])) begin
      timeout_q <= 1'b0;
    end
  end

  // ************************************************
  // Interrupt status and mask
  // ************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_stat_q <= IRQ_RESET;
    end else begin
      if (overflow) begin
        irq_stat_q[IRQ_TIMEOUT] <= 1'b1;
      end else if (wr_istat && reg_wdata[IRQ_TIMEOUT]) begin
        irq_stat_q[IRQ_TIMEOUT] <= 1'b0;
      end
      if (fire) begin
        irq_stat_q[IRQ_KEYFAULT] <= 1'b1;
      end else if (wr_istat && reg_wdata[IRQ_KEYFAULT]) begin
        irq_stat_q[IRQ_KEYFAULT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr_imask) begin
      irq_mask_q <= reg_wdata[1:0];
    end
  end

  // ************************************************
  // Read port
  // ************************************************
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      ADDR_WDT_CTRL:  rdata_d = wdt_ctrl_q;
      ADDR_RST_FLAGS: rdata_d = {sysclk_keep_q, 3'h0, 3'h0, keyfault_q}; // [R12]
      ADDR_WDT_STAT:  rdata_d = {5'h00, (key_state_q != WDTK_RUN), stopped_q, timeout_q};
      ADDR_SUB_SEL:   rdata_d = {7'h00, sub_sel_q};
      ADDR_IRQ_STAT:  rdata_d = {6'h00, irq_stat_q};
      ADDR_IRQ_MASK:  rdata_d = {6'h00, irq_mask_q};
      default:        rdata_d = 8'h00;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign reg_rdata            = rdata_q;
  assign device_reset_req     = dev_rst_q;
  assign pc_sp_reset_req      = pcsp_rst_q;
  assign timeout_status_flag  = timeout_q;
  assign key_fault_reset_flag = keyfault_q;
  assign watchdog_enabled     = enabled;
  assign watchdog_stopped     = stopped_q;
  assign idle_sysclk_keep     = sysclk_keep_q;
  assign irq                  = |(irq_stat_q & irq_mask_q);

endmodule : wdtk_watchdog

// ==== rtl/wdtk_pkg.sv ====
// Package with register map, reset values and timing constants of the keyed watchdog.
package wdtk_pkg;

  // ************************************************
  // Register offsets
  // ************************************************
  localparam logic [7:0] ADDR_WDT_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_RST_FLAGS = 8'h01;
  localparam logic [7:0] ADDR_WDT_STAT  = 8'h02;
  localparam logic [7:0] ADDR_SUB_SEL   = 8'h03;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h05;

  // ************************************************
  // Field positions and values
  // ************************************************
  localparam int          KEY_LSB        = 3;
  localparam int          FLAG_SYSCLK    = 7;
  localparam int          FLAG_KEYFAULT  = 0;
  localparam int          IRQ_TIMEOUT    = 0;
  localparam int          IRQ_KEYFAULT   = 1;
  localparam logic [4:0]  KEY_DISABLE    = 5'h15;
  localparam logic [4:0]  KEY_ENABLE     = 5'h0A;
  localparam logic [7:0]  WDT_CTRL_RESET = 8'h53;
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam logic        SUB_SEL_RESET  = 1'b0;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_NS       = 50;
  localparam int SOFT_RESET_DELAY_NS = 90000;
  localparam int SOFT_RESET_CYCLES   = (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_CNT_WIDTH       = 18;

  typedef enum logic [1:0] {
    WDTK_RUN  = 2'b00,
    WDTK_PEND = 2'b01,
    WDTK_FIRE = 2'b10
  } wdtk_key_state_t;

endpackage : wdtk_pkg

// ==== rtl/wdtk_sub_if.sv ====
// Interface carrying the sub clock selection and its tick between the watchdog modules.
`timescale 1ns/10ps
interface wdtk_sub_if;
  logic use_crystal;
  logic tick;
  modport core (output use_crystal, input tick);
  modport src  (input use_crystal, output tick);
endinterface : wdtk_sub_if

// ==== rtl/wdtk_sub_clock.sv ====
// Sub clock source selection, synchronisation and tick generation.
`timescale 1ns/10ps
module wdtk_sub_clock (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic low_speed_rc_osc,
  input  wire logic low_speed_crystal_osc,
  wdtk_sub_if.src   sub
);

  logic [1:0] rc_sync_q;
  logic [1:0] xt_sync_q;
  logic       sel_prev_q;
  logic       tick_q;

  // ************************************************
  // Synchronisers
  // ************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rc_sync_q <= 2'h0;
      xt_sync_q <= 2'h0;
    end else begin
      rc_sync_q <= {rc_sync_q[0], low_speed_rc_osc};
      xt_sync_q <= {xt_sync_q[0], low_speed_crystal_osc};
    end
  end

  // ************************************************
  // Rising edge of the selected source
  // ************************************************
  // Switching source may yield one stray tick; a single extra count is harmless to the time-out.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_prev_q <= 1'b0;
      tick_q     <= 1'b0;
    end else begin
      sel_prev_q <= sub.use_crystal ? xt_sync_q[1] : rc_sync_q[1];
      tick_q     <= (sub.use_crystal ? xt_sync_q[1] : rc_sync_q[1]) & ~sel_prev_q; // [R01]
    end
  end

  assign sub.tick = tick_q;

endmodule : wdtk_sub_clock

// ==== bench/wdtk_watchdog_properties.sv ====
// Concurrent checks of the keyed watchdog, seen only at its top ports.
`timescale 1ns/10ps
module wdtk_watchdog_properties
  import wdtk_pkg::*;
#(
  parameter int CNT_W         = WDT_CNT_WIDTH,
  parameter int SRESET_CYCLES = SOFT_RESET_CYCLES
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       low_speed_rc_osc,
  input wire logic       low_speed_crystal_osc,
  input wire logic       clear_watchdog_instr,
  input wire logic       halt_instr,
  input wire logic       low_power_mode,
  input wire logic       lvd_enabled,
  input wire logic       wakeup,
  input wire logic       device_reset_req,
  input wire logic       pc_sp_reset_req,
  input wire logic       timeout_status_flag,
  input wire logic       key_fault_reset_flag,
  input wire logic       watchdog_enabled,
  input wire logic       watchdog_stopped,
  input wire logic       idle_sysclk_keep,
  input wire logic       irq
);
  // ************************************************
  // Properties
  // ************************************************
  logic kf_wr0;
  // A write of zero is the only way software may drop the key fault flag.
  assign kf_wr0 = reg_wr && (reg_addr == ADDR_RST_FLAGS) && !reg_wdata[FLAG_KEYFAULT];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_flags_unimpl_zero: assert property (reg_rd && reg_addr == ADDR_RST_FLAGS |=> reg_rdata[6:4] == 3'h0)
    else $error("unimplemented flag bits read nonzero");
  a_reset_pulse_single: assert property (device_reset_req |=> !device_reset_req)
    else $error("device reset request longer than one cycle");
  a_keyflag_with_reset: assert property ($rose(key_fault_reset_flag) |-> ##[0:1] device_reset_req)
    else $error("key fault flag set without device reset");
  a_keyflag_hw_only: assert property ($rose(key_fault_reset_flag) |-> !$past(watchdog_enabled))
    else $error("key fault flag set while key was valid");
  a_keyflag_sw_clear: assert property ($fell(key_fault_reset_flag) |-> $past(kf_wr0) || $past(sys_rst))
    else $error("key fault flag cleared without a zero write");
  // The flag and the reset request are launched by the same edge, so both are seen together.
  a_timeout_run_reset: assert property ($rose(timeout_status_flag) && !low_power_mode
    |-> device_reset_req && !pc_sp_reset_req)
    else $error("overflow in run mode gave no device reset");
  a_timeout_sleep_pcsp: assert property ($rose(timeout_status_flag) && low_power_mode
    |-> pc_sp_reset_req && !device_reset_req)
    else $error("overflow in sleep gave wrong reset");
  a_disabled_no_timeout: assert property ($rose(timeout_status_flag) |-> $past(watchdog_enabled))
    else $error("overflow while watchdog disabled");
  a_halt_clears_flag: assert property (halt_instr |=> !timeout_status_flag)
    else $error("halt left time-out flag set");
  a_halt_stops_off: assert property (halt_instr && !watchdog_enabled && !lvd_enabled |=> watchdog_stopped)
    else $error("halt with watchdog off did not stop it");
  a_halt_keeps_running: assert property (halt_instr && watchdog_enabled && !watchdog_stopped
    |=> !watchdog_stopped)
    else $error("halt stopped an enabled watchdog");
  c_device_reset: cover property (device_reset_req);
  c_pcsp_reset: cover property (pc_sp_reset_req);
  c_stop_wake: cover property (watchdog_stopped && wakeup);
endmodule : wdtk_watchdog_properties

bind wdtk_watchdog wdtk_watchdog_properties #(.CNT_W(CNT_W), .SRESET_CYCLES(SRESET_CYCLES)) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_speed_rc_osc(low_speed_rc_osc),
  .low_speed_crystal_osc(low_speed_crystal_osc), .clear_watchdog_instr(clear_watchdog_instr),
  .halt_instr(halt_instr), .low_power_mode(low_power_mode), .lvd_enabled(lvd_enabled),
  .wakeup(wakeup), .device_reset_req(device_reset_req), .pc_sp_reset_req(pc_sp_reset_req),
  .timeout_status_flag(timeout_status_flag), .key_fault_reset_flag(key_fault_reset_flag),
  .watchdog_enabled(watchdog_enabled), .watchdog_stopped(watchdog_stopped),
  .idle_sysclk_keep(idle_sysclk_keep), .irq(irq)
);

// ==== bench/wdtk_watchdog_bench.sv ====
// Self-checking bench of the keyed watchdog against a small reference model.
`timescale 1ns/10ps
module wdtk_watchdog_bench;
  import wdtk_pkg::*;
  // ************************************************
  // Stimulus, reference model and checks
  // ************************************************
  localparam int SR = 4;  // Short soft reset delay keeps the run brief.
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rc = 1'b0;
  logic        xt = 1'b0;
  logic        clr = 1'b0;
  logic        halt = 1'b0;
  logic        lpm = 1'b0;
  logic        wake = 1'b0;
  logic        lvd = 1'b0;
  logic        keep;
  logic [7:0]  reg_rdata;
  logic        dev_req, pcsp_req, to_flag, kf_flag, en, stopped, irq;
  logic [7:0]  m_ctrl = WDT_CTRL_RESET;
  logic [31:0] xs_q = 32'h84B6;
  logic [4:0]  k;
  int          n_fail = 0, n_compared = 0, n_dev = 0, n_pcsp = 0, base, base2, n, use_xt = 0;
  time         t_dev = 0, t0;

  wdtk_watchdog #(.SRESET_CYCLES(SR)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_speed_rc_osc(rc),
    .low_speed_crystal_osc(xt), .clear_watchdog_instr(clr), .halt_instr(halt),
    .low_power_mode(lpm), .lvd_enabled(lvd), .wakeup(wake), .device_reset_req(dev_req),
    .pc_sp_reset_req(pcsp_req), .timeout_status_flag(to_flag), .key_fault_reset_flag(kf_flag),
    .watchdog_enabled(en), .watchdog_stopped(stopped), .idle_sysclk_keep(keep), .irq(irq)
  );

  always #25 core_clk = ~core_clk;

  // Reset requests are pulses, so they are counted as they pass.
  always @(posedge core_clk) begin
    if (dev_req === 1'b1) begin
      n_dev++;
      t_dev = $time;
    end
    if (pcsp_req === 1'b1) n_pcsp++;
  end

  function automatic logic [31:0] xs();
    xs_q = xs_q ^ (xs_q << 13);
    xs_q = xs_q ^ (xs_q >> 17);
    xs_q = xs_q ^ (xs_q << 5);
    return xs_q;
  endfunction : xs

  function automatic int period(input int s);
    case (s)
      0: return 256;
      1: return 1024;
      2: return 4096;
      3: return 16384;
      default: return 1 << (s + 11);
    endcase
  endfunction : period

  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chkb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd_chk

  task automatic instr(input int kind);
    @(posedge core_clk);
    clr  <= (kind == 0);
    halt <= (kind == 1);
    wake <= (kind == 2);
    @(posedge core_clk);
    clr  <= 1'b0;
    halt <= 1'b0;
    wake <= 1'b0;
    #1;
  endtask : instr

  // Each tick is a full slow period of four core cycles on the selected source.
  task automatic ticks(input int cnt);
    repeat (cnt) begin
      @(posedge core_clk);
      rc <= (use_xt == 0);
      xt <= (use_xt != 0);
      repeat (2) @(posedge core_clk);
      rc <= 1'b0;
      xt <= 1'b0;
      @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    #1;
  endtask : ticks

  initial begin
    #3_000_000;
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_WDT_CTRL, m_ctrl);
    wr(ADDR_RST_FLAGS, 8'hF1);
    rd_chk(ADDR_RST_FLAGS, 8'h80);
    chkb(kf_flag, 1'b0);
    chkb(keep, 1'b1);
    rd_chk(8'h09, 8'h00);
    $display("test reset_values done");
    for (int s = 0; s < 3; s++) begin
      m_ctrl = {KEY_ENABLE, 3'(s)};
      wr(ADDR_WDT_CTRL, m_ctrl);
      rd_chk(ADDR_WDT_CTRL, m_ctrl);
      instr(0);
      base = n_dev;
      ticks(period(s) - 1);
      chkb(to_flag, 1'b0);
      ticks(1);
      chk(8'(n_dev - base), 8'h01);
      chkb(to_flag, 1'b1);
      wr(ADDR_WDT_STAT, 8'h00);
    end
    $display("test periods done");
    m_ctrl = {KEY_ENABLE, 3'h0};
    wr(ADDR_WDT_CTRL, m_ctrl);
    instr(0);
    base = n_dev;
    n = 150 + int'(xs() % 100);
    ticks(n);
    instr(0);
    ticks(n);
    instr(1);
    chkb(stopped, 1'b0);
    ticks(n);
    chk(8'(n_dev - base), 8'h00);
    ticks(256 - n);
    chk(8'(n_dev - base), 8'h01);
    chkb(to_flag, 1'b1);
    wr(ADDR_WDT_STAT, 8'h00);
    $display("test clears done");
    wr(ADDR_SUB_SEL, 8'h01);
    use_xt = 1;
    @(posedge core_clk);
    lpm <= 1'b1;
    instr(0);
    base  = n_pcsp;
    base2 = n_dev;
    ticks(255);
    chk(8'(n_pcsp - base), 8'h00);
    chkb(to_flag, 1'b0);
    ticks(1);
    chk(8'(n_pcsp - base), 8'h01);
    chk(8'(n_dev - base2), 8'h00);
    chkb(to_flag, 1'b1);
    instr(1);
    chkb(to_flag, 1'b0);
    @(posedge core_clk);
    lpm <= 1'b0;
    wr(ADDR_SUB_SEL, 8'h00);
    use_xt = 0;
    $display("test sleep_crystal done");
    m_ctrl = {KEY_DISABLE, 3'h0};
    wr(ADDR_WDT_CTRL, m_ctrl);
    instr(0);
    base = n_dev;
    ticks(300);
    chk(8'(n_dev - base), 8'h00);
    chkb(en, 1'b0);
    // With the voltage detector on, halt must keep the watchdog clock alive.
    @(posedge core_clk);
    lvd <= 1'b1;
    instr(1);
    chkb(stopped, 1'b0);
    @(posedge core_clk);
    lvd <= 1'b0;
    instr(1);
    chkb(stopped, 1'b1);
    instr(2);
    chkb(stopped, 1'b0);
    $display("test disable_halt done");
    wr(ADDR_IRQ_MASK, 8'h02);
    chkb(irq, 1'b0);
    repeat (2) begin
      k = 5'(xs());
      if (k == KEY_ENABLE || k == KEY_DISABLE) k = k ^ 5'h01;
      base = n_dev;
      wr(ADDR_WDT_CTRL, {k, 3'h5});
      t0 = $time - 1;
      chkb(en, 1'b0);
      repeat (SR + 8) @(posedge core_clk);
      #1;
      chk(8'(n_dev - base), 8'h01);
      chk(8'((t_dev - t0) / 50), 8'(SR + 3));
      chkb(kf_flag, 1'b1);
      chkb(irq, 1'b1);
      m_ctrl = WDT_CTRL_RESET;
      rd_chk(ADDR_WDT_CTRL, m_ctrl);
      wr(ADDR_RST_FLAGS, 8'h01);
      chkb(kf_flag, 1'b1);
      wr(ADDR_RST_FLAGS, 8'h00);
      chkb(kf_flag, 1'b0);
      wr(ADDR_IRQ_STAT, 8'h03);
      chkb(irq, 1'b0);
    end
    $display("test bad_key done");
    give_verdict();
  end
endmodule : wdtk_watchdog_bench
